// ---- design/regulator_alt_voltage_regs.sv ----
// alternate voltage set registers for regulators four, five and six
// Functional notes
// - bit seven picks sleep, else normal
// - regulator four seven-bit code, 0.90 V base
// - five/six six-bit code, lowest three 0.90 V
// - code three 0.95 V, 50 mV steps
// - five/six saturate at 3.60 V
`timescale 1ns/1ns
module regulator_alt_voltage_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic alt_set_sel,
    output logic reg4_alt_sleep_sel,
    output logic [6:0] reg4_alt_voltage_code,
    output logic [8:0] reg4_alt_mv10,
    output logic reg5_alt_sleep_sel,
    output logic [5:0] reg5_alt_voltage_code,
    output logic [8:0] reg5_alt_mv10,
    output logic reg6_alt_sleep_sel,
    output logic [5:0] reg6_alt_voltage_code,
    output logic [8:0] reg6_alt_mv10
);
    logic [7:0] cfg_r [3];
    logic [7:0] cfg_nxt [3];
    logic wr_pend_r, wr_pend_nxt;
    logic [1:0] wr_idx_r, wr_idx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [7:0] word_idx;
    logic hit;
    logic [1:0] idx;
    logic [6:0] full_code;
    logic [6:0] code_mask;
    logic [7:0] live [3];

    // bus qualification and field decode nets
    logic addr_phase;
    logic wr_take;
    logic rd_take;
    logic [31:0] rd_word;
    logic [2:0] sleep_live;
    logic [6:0] code4_live;
    logic [5:0] code56_live [2];
    logic [8:0] mv4;
    logic [8:0] mv56 [2];

    assign word_idx = haddr[9:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // transfer qualification, taken at the end of the address phase
    assign addr_phase = hsel && hready && (htrans == regulator_alt_voltage_pkg::HTRANS_NONSEQ);
    assign wr_take = addr_phase && hwrite && hit;
    assign rd_take = addr_phase && !hwrite;

    // read mux sees a write still in its data phase; unmapped reads zero
    always_comb
    begin
        rd_word = 32'h0;
        if (hit)
        begin
            rd_word = {24'h0, cfg_nxt[idx]};
        end
    end

    always_comb
    begin
        hit = 1'b1;
        idx = 2'd0;
        case (word_idx)
            regulator_alt_voltage_pkg::REG4_IDX: idx = 2'd0;
            regulator_alt_voltage_pkg::REG5_IDX: idx = 2'd1;
            regulator_alt_voltage_pkg::REG6_IDX: idx = 2'd2;
            default: hit = 1'b0;
        endcase
        if (haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0)
        begin
            hit = 1'b0;
        end
    end

    // field mask: reserved bit six of five/six holds zero
    always_comb
    begin
        code_mask = (wr_idx_r == 2'd0) ? 7'h7F : 7'h3F;
        full_code = hwdata[6:0] & code_mask;
    end

    always_comb
    begin
        wr_pend_nxt = 1'b0;
        wr_idx_nxt = wr_idx_r;
        hrdata_nxt = hrdata_r;
        for (int i = 0; i < 3; i++)
        begin
            cfg_nxt[i] = cfg_r[i];
        end
        if (wr_pend_r)
        begin
            cfg_nxt[wr_idx_r] = {hwdata[regulator_alt_voltage_pkg::SLEEP_BIT], full_code};
        end
        if (wr_take)
        begin
            wr_pend_nxt = 1'b1;
            wr_idx_nxt = idx;
        end
        if (rd_take)
        begin
            hrdata_nxt = rd_word;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cfg_r[i] <= regulator_alt_voltage_pkg::CFG_RESET;
            end
            wr_pend_r <= 1'b0;
            wr_idx_r <= 2'd0;
            hrdata_r <= 32'h0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r <= wr_idx_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // gate by alternate set select
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gate_g
            assign live[g] = alt_set_sel ? cfg_r[g] : 8'h00;
        end
    endgenerate

    // split the gated words into their fields
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            sleep_live[i] = live[i][regulator_alt_voltage_pkg::SLEEP_BIT];
        end
        code4_live = live[0][regulator_alt_voltage_pkg::CODE4_W-1:0];
        code56_live[0] = live[1][regulator_alt_voltage_pkg::CODE56_W-1:0];
        code56_live[1] = live[2][regulator_alt_voltage_pkg::CODE56_W-1:0];
    end

    // seven-bit code: linear from the base in 20 mV steps
    always_comb
    begin
        mv4 = regulator_alt_voltage_pkg::MV10_MIN
            + 9'(regulator_alt_voltage_pkg::STEP4_MV10 * 9'(code4_live));
    end

    // six-bit code: floor, 50 mV line, then saturation; one copy per regulator
    generate
        for (g = 0; g < 2; g++)
        begin : dec56_g
            logic sat_hit;
            logic step_hit;
            logic [8:0] step_v;

            always_comb
            begin
                sat_hit = (code56_live[g] == regulator_alt_voltage_pkg::CODE56_SAT)
                    || (code56_live[g] >= regulator_alt_voltage_pkg::CODE56_SAT_HI);
                step_hit = code56_live[g]
                    >= regulator_alt_voltage_pkg::CODE56_FIRST_STEP;
                step_v = regulator_alt_voltage_pkg::MV10_AT_FIRST_STEP
                    + 9'(regulator_alt_voltage_pkg::STEP56_MV10
                    * 9'(code56_live[g] - regulator_alt_voltage_pkg::CODE56_FIRST_STEP));
                if (sat_hit)
                begin
                    mv56[g] = regulator_alt_voltage_pkg::MV10_MAX56;
                end
                else if (step_hit && step_v > regulator_alt_voltage_pkg::MV10_MAX56)
                begin
                    mv56[g] = regulator_alt_voltage_pkg::MV10_MAX56;
                end
                else if (step_hit)
                begin
                    mv56[g] = step_v;
                end
                else
                begin
                    mv56[g] = regulator_alt_voltage_pkg::MV10_MIN;
                end
            end
        end
    endgenerate

    // gated fields to the regulator control
    assign reg4_alt_sleep_sel = sleep_live[0];
    assign reg5_alt_sleep_sel = sleep_live[1];
    assign reg6_alt_sleep_sel = sleep_live[2];
    assign reg4_alt_voltage_code = code4_live;
    assign reg5_alt_voltage_code = code56_live[0];
    assign reg6_alt_voltage_code = code56_live[1];
    assign reg4_alt_mv10 = mv4;
    assign reg5_alt_mv10 = mv56[0];
    assign reg6_alt_mv10 = mv56[1];
endmodule // regulator_alt_voltage_regs

// ---- design/regulator_alt_voltage_pkg.sv ----
// shared constants for the alternate voltage register bank
package regulator_alt_voltage_pkg;
    // printed offsets are not multiples of four: indices, byte address = 4 * index
    localparam logic [7:0] REG4_IDX = 8'hBD;
    localparam logic [7:0] REG5_IDX = 8'hBE;
    localparam logic [7:0] REG6_IDX = 8'hBF;
    localparam int SLEEP_BIT = 7;
    localparam int CODE4_W = 7;
    localparam int CODE56_W = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // decoded output in units of 10 mV
    localparam logic [8:0] MV10_MIN = 9'h05A;
    localparam logic [8:0] MV10_MAX56 = 9'h168;
    localparam logic [8:0] STEP4_MV10 = 9'h002;
    localparam logic [8:0] STEP56_MV10 = 9'h005;
    localparam logic [5:0] CODE56_FIRST_STEP = 6'h03;
    localparam logic [5:0] CODE56_SAT = 6'h34;
    localparam logic [5:0] CODE56_SAT_HI = 6'h38;
    localparam logic [8:0] MV10_AT_FIRST_STEP = 9'h05F;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ---- tb/regulator_alt_voltage_checker.sv ----
// output checker for the alternate voltage bank
`timescale 1ns/1ns
module regulator_alt_voltage_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic alt_set_sel,
    input wire logic [5:0] reg6_alt_voltage_code,
    input wire logic [8:0] reg6_alt_mv10,
    input wire logic [6:0] reg4_alt_voltage_code,
    input wire logic [8:0] reg4_alt_mv10,
    input wire logic [5:0] reg5_alt_voltage_code,
    input wire logic [8:0] reg5_alt_mv10
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_code4; reg4_alt_mv10 == 9'h05A + {reg4_alt_voltage_code, 1'b0}; endproperty
    a_code4: assert property (p_code4) else $error("code4");
    property p_low; reg5_alt_voltage_code < 6'h03 |-> reg5_alt_mv10 == 9'h05A; endproperty
    a_low: assert property (p_low) else $error("low");
    property p_step;
        reg5_alt_voltage_code inside {[6'h03:6'h33]} |->
            reg5_alt_mv10 == 9'h05F + 9'h005 * (reg5_alt_voltage_code - 6'h03);
    endproperty
    a_step: assert property (p_step) else $error("step");
    property p_sat;
        reg5_alt_voltage_code inside {6'h34, [6'h38:6'h3F]} |-> reg5_alt_mv10 == 9'h168;
    endproperty
    a_sat: assert property (p_sat) else $error("sat");
    property p_gate;
        !alt_set_sel |-> reg4_alt_voltage_code == 7'h00 && reg5_alt_mv10 == 9'h05A;
    endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_sat6;
        reg6_alt_voltage_code inside {6'h34, [6'h38:6'h3F]} |-> reg6_alt_mv10 == 9'h168;
    endproperty
    a_sat6: assert property (p_sat6) else $error("sat6");
    sequence s_wr5_addr;
        hsel && hready && htrans == 2'h2 && hwrite && haddr == 32'h2F8;
    endsequence
    sequence s_wr5_data;
        hready;
    endsequence
    property p_wr5;
        s_wr5_addr ##1 s_wr5_data |=> !alt_set_sel || reg5_alt_voltage_code == $past(hwdata[5:0]);
    endproperty
    a_wr5: assert property (p_wr5) else $error("wr5");
endmodule // regulator_alt_voltage_checker
bind regulator_alt_voltage_regs regulator_alt_voltage_checker regulator_alt_voltage_checker_i (.*);

// ---- tb/tb_regulator_alt_voltage_regs.sv ----
// bench for the alternate voltage bank
`timescale 1ns/1ns
module tb_regulator_alt_voltage_regs;
    logic mclk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, alt_set_sel = 1'b1, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic reg4_alt_sleep_sel, reg5_alt_sleep_sel, reg6_alt_sleep_sel;
    logic [6:0] reg4_alt_voltage_code;
    logic [5:0] reg5_alt_voltage_code, reg6_alt_voltage_code;
    logic [8:0] reg4_alt_mv10, reg5_alt_mv10, reg6_alt_mv10;
    int miscompares = 0, checks = 0;
    regulator_alt_voltage_regs regulator_alt_voltage_regs_i (.*, .hsel(1'b1), .hsize(3'h2),
        .hready(hreadyout));
    always #5 mclk = ~mclk;
    task automatic close_out;
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask
    task automatic t_reg4;
        logic [7:0] v[2] = '{8'h81, 8'h7F};
        foreach (v[i])
        begin
            xfer(1'b1, 32'h2F4, {24'h0, v[i]});
            xfer(1'b0, 32'h2F4, 32'h0);
            chk("rd4", {24'h0, v[i]}, hrdata);
            chk("out4", v[i], {reg4_alt_sleep_sel, reg4_alt_voltage_code});
            chk("mv4", 32'h5A + 32'h2 * v[i][6:0], reg4_alt_mv10);
        end
    endtask
    task automatic t_reg56;
        logic [5:0] c[5] = '{6'h02, 6'h03, 6'h04, 6'h34, 6'h3F};
        logic [8:0] e[5] = '{9'h05A, 9'h05F, 9'h064, 9'h168, 9'h168};
        foreach (c[i])
        begin
            xfer(1'b1, 32'h2F8, {24'h0, 2'h3, c[i]});
            xfer(1'b1, 32'h2FC, {24'h0, 2'h1, c[i]});
            xfer(1'b0, 32'h2F8, 32'h0);
            chk("rd5", {24'h0, 2'h2, c[i]}, hrdata);
            chk("mv56", {e[i], e[i]}, {reg5_alt_mv10, reg6_alt_mv10});
            chk("sl56", 32'h2, {reg5_alt_sleep_sel, reg6_alt_sleep_sel});
            chk("code56", {c[i], c[i]}, {reg5_alt_voltage_code, reg6_alt_voltage_code});
        end
    endtask
    task automatic t_gate;
        alt_set_sel <= 1'b0;
        xfer(1'b1, 32'h2F0, 32'hFF);
        xfer(1'b0, 32'h2F0, 32'h0);
        chk("unmapped", 32'h0, hrdata);
        chk("okay", 32'h1, {hresp, hreadyout});
        chk("gated", 32'h5A, {reg4_alt_sleep_sel, reg6_alt_voltage_code, reg5_alt_mv10});
    endtask
    task automatic t_reset;
        xfer(1'b1, 32'h2F4, 32'hFF);
        rst_n <= 1'b0;
        @(posedge mclk);
        chk("rst_rd", 32'h0, hrdata);
        chk("rst_out4", 32'h5A, {reg4_alt_sleep_sel, reg4_alt_voltage_code, reg4_alt_mv10});
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reg4;
        t_reg56;
        t_reset;
        t_gate;
        close_out;
    end
    initial
    begin
        repeat (500) @(posedge mclk);
        miscompares++;
        close_out;
    end
endmodule // tb_regulator_alt_voltage_regs
